// ---- core/gpt_timer_consts.vh ----
`ifndef GPT_TIMER_CONSTS_VH
`define GPT_TIMER_CONSTS_VH

// Register byte offsets.
`define GPT_A_CTRL_OFS      8'h00
`define GPT_A_COUNT_OFS     8'h04
`define GPT_A_PERIOD_OFS    8'h08
`define GPT_INT_STATUS_OFS  8'h0C
`define GPT_INT_MASK_OFS    8'h10
`define GPT_B_BASE_OFS      8'h20
`define GPT_B_STRIDE        8'h10
`define GPT_B_CTRL_SUB      4'h0
`define GPT_B_COUNT_SUB     4'h4
`define GPT_B_PERIOD_SUB    4'h8

// Control register field positions.
`define GPT_CTL_ON          15
`define GPT_CTL_STOP_IDLE   13
`define GPT_CTL_WR_DIS      12
`define GPT_CTL_WR_PEND     11
`define GPT_CTL_ECS_HI      9
`define GPT_CTL_ECS_LO      8
`define GPT_CTL_GATE        7
`define GPT_CTL_PS_HI       5
`define GPT_CTL_PS_LO       4
`define GPT_CTL_SYNC        2
`define GPT_CTL_CS          1

// Field codes and reset values.
`define GPT_ECS_PIN         2'h1
`define GPT_CTRL_RST        16'h0000
`define GPT_PERIOD_RST      16'hFFFF

// Prescaler terminal counts for divide by 1, 8, 64 and 256.
`define GPT_PS_LIM_0        8'h00
`define GPT_PS_LIM_1        8'h07
`define GPT_PS_LIM_2        8'h3F
`define GPT_PS_LIM_3        8'hFF

// Counts of cycles and pulses.
`define GPT_WR_SPACING      4
`define GPT_WAKE_HOLD       3'h5

`endif

// ---- core/gpt_timer_b.v ----
`timescale 1ns/100ps
`include "gpt_timer_consts.vh"

// One type-B timer: control, counter and period with a match event.
module gpt_timer_b #(
    parameter WIDTH = 16
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             wr_ctrl,
    input  wire             wr_count,
    input  wire             wr_period,
    input  wire [WIDTH-1:0] wdata,
    input  wire             idle_mode,
    input  wire             sleep_mode,
    output reg  [15:0]      ctrl_reg,
    output reg  [WIDTH-1:0] count_reg,
    output reg  [WIDTH-1:0] period_reg,
    output reg              match_reg
);
    reg  [7:0] ps_reg;
    reg  [7:0] ps_lim;
    wire       run;
    wire       tick;

    // Terminal count of the prescaler from the two-bit select field.
    always @* begin
        case (ctrl_reg[`GPT_CTL_PS_HI:`GPT_CTL_PS_LO])
            2'h0:    ps_lim = `GPT_PS_LIM_0;
            2'h1:    ps_lim = `GPT_PS_LIM_1;
            2'h2:    ps_lim = `GPT_PS_LIM_2;
            default: ps_lim = `GPT_PS_LIM_3;
        endcase
    end

    // Halted in Sleep, and in Idle when asked to stop there.
    assign run = ctrl_reg[`GPT_CTL_ON] & ~sleep_mode &
                 ~(idle_mode & ctrl_reg[`GPT_CTL_STOP_IDLE]);
    assign tick = run & (ps_reg == ps_lim);

    // Registers, prescaler, counter and match event.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg   <= `GPT_CTRL_RST;
            count_reg  <= {WIDTH{1'b0}};
            period_reg <= {WIDTH{1'b1}};
            match_reg  <= 1'b0;
            ps_reg     <= 8'h00;
        end else begin
            match_reg <= 1'b0;
            if (wr_ctrl) begin
                ctrl_reg <= wdata[15:0];
            end
            if (wr_period) begin
                period_reg <= wdata;
            end
            if (!run || tick) begin
                ps_reg <= 8'h00;
            end else begin
                ps_reg <= ps_reg + 8'h01;
            end
            if (wr_count) begin
                count_reg <= wdata;
            end else if (tick) begin
                if (count_reg == period_reg) begin
                    count_reg <= {WIDTH{1'b0}};
                    match_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end
endmodule // gpt_timer_b

// ---- core/gpt_timer_top.v ----
// Functional notes
// - Type A counts the pin asynchronously when source is 1, sync 0, select 01.
// - Type A has a gated mode on the internal source and a 2-bit prescaler.
// - Type A counts up to and wraps on its period; period 1 is not advised.
// - The control register holds write disable at 12 and pending at 11.
// - A type-B timer with stop-in-idle set halts while the device idles.
// - A type-B match raises an event trigger and sets its interrupt flag.
// - After wake from Sleep in async mode type A holds for five pulses.
`timescale 1ns/100ps
`include "gpt_timer_consts.vh"

module gpt_timer_top #(
    parameter WIDTH = 16,
    parameter NUM_B = 2
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [7:0]       reg_addr,
    input  wire [31:0]      reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [31:0]      reg_rdata,
    input  wire             external_count_input,
    input  wire             idle_mode,
    input  wire             sleep_mode,
    output reg              irq,
    output reg  [NUM_B-1:0] type_b_event
);
    reg  [15:0]          type_a_control_reg;
    reg  [WIDTH-1:0]     type_a_counter_reg;
    reg  [WIDTH-1:0]     type_a_period_reg;
    reg  [WIDTH-1:0]     pend_val_reg;
    reg                  async_write_pending_reg;
    reg  [NUM_B:0]       status_reg;
    reg  [NUM_B:0]       mask_reg;
    reg                  pin_s1_reg;
    reg                  pin_s2_reg;
    reg                  pin_prev_reg;
    reg                  sleep_prev_reg;
    reg  [2:0]           hold_reg;
    reg  [7:0]           ps_reg;
    reg  [7:0]           ps_lim;
    reg  [31:0]          rdata_next;
    reg  [NUM_B:0]       status_next;
    reg  [NUM_B-1:0]     b_wr_ctrl;
    reg  [NUM_B-1:0]     b_wr_count;
    reg  [NUM_B-1:0]     b_wr_period;
    wire [16*NUM_B-1:0]  b_ctrl;
    wire [WIDTH*NUM_B-1:0] b_count;
    wire [WIDTH*NUM_B-1:0] b_period;
    wire [NUM_B-1:0]     b_match;
    wire                 a_on;
    wire                 cs_sel;
    wire                 sync_sel;
    wire                 pin_sel;
    wire                 gate_mode_enable;
    wire                 async_mode;
    wire                 pin_rise;
    wire                 src_evt;
    wire                 run_a;
    wire                 tick_a;
    wire                 a_match;
    wire                 wr_a_ctrl;
    wire                 wr_a_count;
    wire                 wr_a_period;
    wire                 wr_status;
    wire                 wr_mask;
    wire                 wake;
    integer              i;
    integer              j;

    // Field decode of the type-A control register.
    assign a_on        = type_a_control_reg[`GPT_CTL_ON];
    assign cs_sel      = type_a_control_reg[`GPT_CTL_CS];
    assign sync_sel    = type_a_control_reg[`GPT_CTL_SYNC];
    assign gate_mode_enable = type_a_control_reg[`GPT_CTL_GATE];
    assign pin_sel     = type_a_control_reg[`GPT_CTL_ECS_HI:`GPT_CTL_ECS_LO]
                         == `GPT_ECS_PIN;
    assign async_mode  = cs_sel & ~sync_sel & pin_sel;

    // Register strobes for the shared registers.
    assign wr_a_ctrl   = reg_wr & (reg_addr == `GPT_A_CTRL_OFS);
    assign wr_a_count  = reg_wr & (reg_addr == `GPT_A_COUNT_OFS);
    assign wr_a_period = reg_wr & (reg_addr == `GPT_A_PERIOD_OFS);
    assign wr_status   = reg_wr & (reg_addr == `GPT_INT_STATUS_OFS);
    assign wr_mask     = reg_wr & (reg_addr == `GPT_INT_MASK_OFS);

    // Strobes for each type-B timer from its slot in the map.
    always @* begin
        for (i = 0; i < NUM_B; i = i + 1) begin
            b_wr_ctrl[i]   = reg_wr & (reg_addr == `GPT_B_BASE_OFS +
                             i * `GPT_B_STRIDE + `GPT_B_CTRL_SUB);
            b_wr_count[i]  = reg_wr & (reg_addr == `GPT_B_BASE_OFS +
                             i * `GPT_B_STRIDE + `GPT_B_COUNT_SUB);
            b_wr_period[i] = reg_wr & (reg_addr == `GPT_B_BASE_OFS +
                             i * `GPT_B_STRIDE + `GPT_B_PERIOD_SUB);
        end
    end

    // Type-B timers, one instance per slot.
    genvar g;
    generate
        for (g = 0; g < NUM_B; g = g + 1) begin : gen_b
            gpt_timer_b #(
                .WIDTH      (WIDTH)
            ) u_b (
                .ref_clk    (ref_clk),
                .rst        (rst),
                .wr_ctrl    (b_wr_ctrl[g]),
                .wr_count   (b_wr_count[g]),
                .wr_period  (b_wr_period[g]),
                .wdata      (reg_wdata[WIDTH-1:0]),
                .idle_mode  (idle_mode),
                .sleep_mode (sleep_mode),
                .ctrl_reg   (b_ctrl[16*g +: 16]),
                .count_reg  (b_count[WIDTH*g +: WIDTH]),
                .period_reg (b_period[WIDTH*g +: WIDTH]),
                .match_reg  (b_match[g])
            );
        end
    endgenerate

    // Pin synchroniser; only the second stage and its delay are looked at.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_reg     <= 1'b0;
            pin_s2_reg     <= 1'b0;
            pin_prev_reg   <= 1'b0;
            sleep_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg     <= external_count_input;
            pin_s2_reg     <= pin_s1_reg;
            pin_prev_reg   <= pin_s2_reg;
            sleep_prev_reg <= sleep_mode;
        end
    end

    assign pin_rise = pin_s2_reg & ~pin_prev_reg;
    assign wake     = sleep_prev_reg & ~sleep_mode;

    // Count source: pin edges, or the internal clock gated by the pin.
    assign src_evt = cs_sel ? (pin_sel & pin_rise) :
                     (gate_mode_enable ? pin_s2_reg : 1'b1);

    // Only the asynchronous mode keeps counting through Sleep.
    assign run_a  = a_on & ~(idle_mode &
                    type_a_control_reg[`GPT_CTL_STOP_IDLE]) &
                    (~sleep_mode | async_mode);
    assign tick_a = run_a & src_evt & (ps_reg == ps_lim) & (hold_reg == 3'h0);
    assign a_match = tick_a & (type_a_counter_reg == type_a_period_reg);

    // Prescaler terminal count from the select field.
    always @* begin
        case (type_a_control_reg[`GPT_CTL_PS_HI:`GPT_CTL_PS_LO])
            2'h0:    ps_lim = `GPT_PS_LIM_0;
            2'h1:    ps_lim = `GPT_PS_LIM_1;
            2'h2:    ps_lim = `GPT_PS_LIM_2;
            default: ps_lim = `GPT_PS_LIM_3;
        endcase
    end

    // Prescaler advances on each source event while running and no wake hold is left.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ps_reg <= 8'h00;
        end else if (!run_a) begin
            ps_reg <= 8'h00;
        end else if (src_evt && hold_reg == 3'h0) begin
            if (ps_reg == ps_lim) begin
                ps_reg <= 8'h00;
            end else begin
                ps_reg <= ps_reg + 8'h01;
            end
        end
    end

    // Wake from Sleep in async mode swallows five pin pulses.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_reg <= 3'h0;
        end else if (wake && async_mode && a_on) begin
            hold_reg <= `GPT_WAKE_HOLD;
        end else if (!async_mode) begin
            hold_reg <= 3'h0;
        end else if (pin_rise && hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end
    end

    // Type-A control and period registers; pending bit is read only.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            type_a_control_reg <= `GPT_CTRL_RST;
            type_a_period_reg  <= {WIDTH{1'b1}};
        end else begin
            if (wr_a_ctrl) begin
                type_a_control_reg <= {reg_wdata[15:12], 1'b0,
                                       reg_wdata[10:0]};
            end
            if (wr_a_period) begin
                type_a_period_reg <= reg_wdata[WIDTH-1:0];
            end
        end
    end

    // Counter: async writes wait for the next pin edge; match wraps to 0.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            type_a_counter_reg      <= {WIDTH{1'b0}};
            pend_val_reg            <= {WIDTH{1'b0}};
            async_write_pending_reg <= 1'b0;
        end else begin
            if (wr_a_count && async_mode) begin
                if (!(async_write_pending_reg &&
                      type_a_control_reg[`GPT_CTL_WR_DIS])) begin
                    pend_val_reg            <= reg_wdata[WIDTH-1:0];
                    async_write_pending_reg <= 1'b1;
                end
            end else if (async_write_pending_reg &&
                         (pin_rise || !async_mode)) begin
                type_a_counter_reg      <= pend_val_reg;
                async_write_pending_reg <= 1'b0;
            end
            if (wr_a_count && !async_mode) begin
                type_a_counter_reg <= reg_wdata[WIDTH-1:0];
            end else if (a_match) begin
                type_a_counter_reg <= {WIDTH{1'b0}};
            end else if (tick_a && !(async_write_pending_reg && pin_rise)) begin
                type_a_counter_reg <= type_a_counter_reg + 1'b1;
            end
        end
    end

    // Sticky status: a new event wins over a write-one clear.
    always @* begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~reg_wdata[NUM_B:0];
        end
        status_next = status_next | {b_match, a_match};
    end

    // Status, mask, interrupt line and event triggers.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_reg   <= {(NUM_B+1){1'b0}};
            mask_reg     <= {(NUM_B+1){1'b0}};
            irq          <= 1'b0;
            type_b_event <= {NUM_B{1'b0}};
        end else begin
            status_reg   <= status_next;
            irq          <= |(status_next & (wr_mask ?
                            reg_wdata[NUM_B:0] : mask_reg));
            type_b_event <= b_match;
            if (wr_mask) begin
                mask_reg <= reg_wdata[NUM_B:0];
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always @* begin
        rdata_next = 32'h00000000;
        case (reg_addr)
            `GPT_A_CTRL_OFS: begin
                rdata_next[15:0] = type_a_control_reg;
                rdata_next[`GPT_CTL_WR_PEND] = async_write_pending_reg;
            end
            `GPT_A_COUNT_OFS:    rdata_next[WIDTH-1:0] = type_a_counter_reg;
            `GPT_A_PERIOD_OFS:   rdata_next[WIDTH-1:0] = type_a_period_reg;
            `GPT_INT_STATUS_OFS: rdata_next[NUM_B:0] = status_reg;
            `GPT_INT_MASK_OFS:   rdata_next[NUM_B:0] = mask_reg;
            default: begin
                for (j = 0; j < NUM_B; j = j + 1) begin
                    if (reg_addr == `GPT_B_BASE_OFS + j * `GPT_B_STRIDE +
                        `GPT_B_CTRL_SUB) begin
                        rdata_next[15:0] = b_ctrl[16*j +: 16];
                    end
                    if (reg_addr == `GPT_B_BASE_OFS + j * `GPT_B_STRIDE +
                        `GPT_B_COUNT_SUB) begin
                        rdata_next[WIDTH-1:0] = b_count[WIDTH*j +: WIDTH];
                    end
                    if (reg_addr == `GPT_B_BASE_OFS + j * `GPT_B_STRIDE +
                        `GPT_B_PERIOD_SUB) begin
                        rdata_next[WIDTH-1:0] = b_period[WIDTH*j +: WIDTH];
                    end
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // gpt_timer_top

// ---- testbench/gpt_timer_chk.sv ----
`timescale 1ns/100ps

// Port-level checks of the timer block's bus, interrupt and event outputs.
module gpt_timer_chk #(
    parameter WIDTH = 16,
    parameter NUM_B = 2
) (
    input wire             ref_clk,
    input wire             rst,
    input wire [7:0]       reg_addr,
    input wire [31:0]      reg_wdata,
    input wire             reg_wr,
    input wire             reg_rd,
    input wire [31:0]      reg_rdata,
    input wire             external_count_input,
    input wire             idle_mode,
    input wire             sleep_mode,
    input wire             irq,
    input wire [NUM_B-1:0] type_b_event
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Read data is only driven in the cycle after a read strobe.
    property p_rd_quiet;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data not zero outside a read cycle");

    // Unmapped addresses read back as zero.
    property p_unmapped;
        reg_rd && reg_addr == 8'h14 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read not zero");

    // Registers are 16 bits wide, so the upper half always reads zero.
    property p_upper_zero;
        reg_rd |=> reg_rdata[31:16] == 16'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read data bits not zero");

    // A type-A period write is visible to a read right behind it.
    property p_a_period_rb;
        (reg_wr && reg_addr == 8'h08) ##1 (reg_rd && reg_addr == 8'h08)
            |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 2)};
    endproperty
    a_a_period_rb: assert property (p_a_period_rb)
        else $error("type-A period read back wrong");

    // A type-B period write is visible to a read right behind it.
    property p_b_period_rb;
        (reg_wr && reg_addr == 8'h28) ##1 (reg_rd && reg_addr == 8'h28)
            |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 2)};
    endproperty
    a_b_period_rb: assert property (p_b_period_rb)
        else $error("type-B period read back wrong");

    // Type-B timers are frozen in Sleep, so no match event can appear.
    property p_sleep_quiet;
        sleep_mode [*3] |-> type_b_event == {NUM_B{1'b0}};
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("type-B event during Sleep");

    // A match event is already recorded in the status flag.
    property p_event_status;
        type_b_event[0] && reg_rd && reg_addr == 8'h0C |=> reg_rdata[1];
    endproperty
    a_event_status: assert property (p_event_status)
        else $error("match event without its status flag");

    // Clearing the mask drops the interrupt the next cycle; it is checked two cycles later.
    property p_mask_irq;
        (reg_wr && reg_addr == 8'h10 && reg_wdata[2:0] == 3'h0)
            ##1 !(reg_wr && reg_addr == 8'h10) |=> !irq;
    endproperty
    a_mask_irq: assert property (p_mask_irq)
        else $error("interrupt high with all sources masked");
endmodule // gpt_timer_chk

bind gpt_timer_top gpt_timer_chk #(.WIDTH(WIDTH), .NUM_B(NUM_B)) u_chk (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .external_count_input (external_count_input),
    .idle_mode            (idle_mode),
    .sleep_mode           (sleep_mode),
    .irq                  (irq),
    .type_b_event         (type_b_event)
);

// ---- testbench/tb_gpt_timer_top.sv ----
`timescale 1ns/100ps

// Register-level tests of the timer block through its plain bus port.
module tb_gpt_timer_top;
    reg         ref_clk;
    reg         rst;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [31:0] reg_rdata;
    reg         external_count_input;
    reg         idle_mode;
    reg         sleep_mode;
    wire        irq;
    wire [1:0]  type_b_event;
    integer     bad_count;
    integer     total_checks;
    integer     cyc = 0;
    integer     last0 = 0;
    integer     gap0 = 0;
    integer     ev0_cnt = 0;
    integer     ev1_cnt = 0;
    integer     c;

    gpt_timer_top #(.WIDTH(16), .NUM_B(2)) dut (
        .ref_clk              (ref_clk),
        .rst                  (rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .external_count_input (external_count_input),
        .idle_mode            (idle_mode),
        .sleep_mode           (sleep_mode),
        .irq                  (irq),
        .type_b_event         (type_b_event)
    );

    // Free-running 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Counts type-B events and measures the spacing of timer 0 events.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (type_b_event[0] === 1'b1) begin
            ev0_cnt <= ev0_cnt + 1;
            gap0 <= cyc - last0;
            last0 <= cyc;
        end
        if (type_b_event[1] === 1'b1) begin
            ev1_cnt <= ev1_cnt + 1;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input [7:0] a, input [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Read data is taken at the edge closing the cycle in which it stands.
    task rdc(input [7:0] a, input [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata, e);
    endtask

    // Write immediately followed by a read of the same register.
    task wr_rd(input [7:0] a, input [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata, {16'h0, v[15:0]});
    endtask

    // Reads the status register every cycle until bit b is seen set.
    task poll(input integer b);
        integer n;
        n = 0;
        reg_addr <= 8'h0C;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        while (reg_rdata[b] !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n = n + 1;
        end
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata[b], 32'h1);
    endtask

    task pulse(input integer k);
        repeat (k) begin
            external_count_input <= 1'b1;
            repeat (4) @(posedge ref_clk);
            external_count_input <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count = bad_count + 1;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end

    // Main sequence of register-level scenarios.
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        external_count_input = 1'b0;
        idle_mode = 1'b0;
        sleep_mode = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'hFFFF);
        rdc(8'h0C, 32'h0);
        rdc(8'h10, 32'h0);
        rdc(8'h20, 32'h0);
        rdc(8'h28, 32'hFFFF);
        wr(8'h14, 32'h1234);
        rdc(8'h14, 32'h0);
        wr(8'h00, 32'h1800);
        rdc(8'h00, 32'h1000);
        wr(8'h00, 32'h8080);
        repeat (6) @(posedge ref_clk);
        rdc(8'h04, 32'h0);
        external_count_input <= 1'b1;
        repeat (20) @(posedge ref_clk);
        external_count_input <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rdc(8'h04, 32'h14);
        wr(8'h00, 32'h8090);
        wr(8'h04, 32'h0);
        external_count_input <= 1'b1;
        repeat (80) @(posedge ref_clk);
        external_count_input <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rdc(8'h04, 32'hA);
        wr_rd(8'h08, 32'h5);
        wr(8'h00, 32'h8102);
        wr(8'h04, 32'h3);
        rdc(8'h00, 32'h8902);
        rdc(8'h04, 32'hA);
        pulse(1);
        rdc(8'h04, 32'h3);
        rdc(8'h00, 32'h8102);
        pulse(2);
        rdc(8'h04, 32'h5);
        pulse(1);
        rdc(8'h04, 32'h0);
        rdc(8'h0C, 32'h1);
        wr(8'h10, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h1);
        wr(8'h10, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h0);
        wr(8'h10, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h1);
        wr(8'h0C, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(irq, 32'h0);
        rdc(8'h0C, 32'h0);
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h9102);
        wr(8'h04, 32'h7);
        repeat (3) @(posedge ref_clk);
        wr(8'h04, 32'h9);
        pulse(1);
        rdc(8'h04, 32'h7);
        sleep_mode <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sleep_mode <= 1'b0;
        @(posedge ref_clk);
        pulse(5);
        rdc(8'h04, 32'h7);
        pulse(1);
        rdc(8'h04, 32'h8);
        wr_rd(8'h28, 32'h9);
        wr(8'h20, 32'h8000);
        poll(1);
        repeat (25) @(posedge ref_clk);
        chk(gap0, 32'hA);
        wr(8'h38, 32'h3);
        wr(8'h30, 32'h8000);
        poll(2);
        chk(ev1_cnt != 0, 32'h1);
        wr(8'h20, 32'hA000);
        idle_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        c = ev0_cnt;
        repeat (40) @(posedge ref_clk);
        chk(ev0_cnt - c, 32'h0);
        wr(8'h20, 32'h8000);
        repeat (40) @(posedge ref_clk);
        chk(ev0_cnt - c > 2, 32'h1);
        idle_mode <= 1'b0;
        // Running type-B timer 0 must stay silent through Sleep.
        sleep_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        c = ev0_cnt;
        repeat (30) @(posedge ref_clk);
        chk(ev0_cnt - c, 32'h0);
        sleep_mode <= 1'b0;
        // Divide by 8 on timer 0 stretches the match spacing to 80 cycles.
        wr(8'h20, 32'h8010);
        repeat (260) @(posedge ref_clk);
        chk(gap0, 32'h50);
        // With the sync bit set, counter writes load at once, no pending.
        wr(8'h00, 32'h8106);
        wr(8'h04, 32'h2);
        rdc(8'h04, 32'h2);
        rdc(8'h00, 32'h8106);
        pulse(1);
        rdc(8'h04, 32'h3);
        test_done;
    end
endmodule // tb_gpt_timer_top
